/* rtl/sddf_cfg.svh */
// Offsets, field positions, reset values and timing counts of the filter
`ifndef SDDF_CFG_SVH
`define SDDF_CFG_SVH

// Register word addresses
`define SDDF_ADDR_CLOCK 4'h0
`define SDDF_ADDR_CHAN 4'h1
`define SDDF_ADDR_STATUS 4'h2
`define SDDF_ADDR_DATA 4'h3

// Clock register fields
`define SDDF_PWR_LSB 0
`define SDDF_PWR_MSB 1
`define SDDF_OSR_LSB 2
`define SDDF_OSR_MSB 4
`define SDDF_EN_BIT 8

// Channel register fields
`define SDDF_MUX_LSB 0
`define SDDF_MUX_MSB 1
`define SDDF_GAIN_LSB 4
`define SDDF_GAIN_MSB 6

// Reset values
`define SDDF_RST_OSR 3'h3
`define SDDF_RST_PWR 2'h2
`define SDDF_RST_EN 1'h1
`define SDDF_RST_MUX 2'h0
`define SDDF_RST_GAIN 3'h0

// Ratio code 0 selects 2^7; sinc3 alone reaches 2^10
`define SDDF_LOG_BASE 4'h7
`define SDDF_S3_LOG_MAX 4'hA
`define SDDF_S3_FS_MAX 6'h1E

// Modulator runs at master clock divided by two
`define SDDF_MOD_DIV 2

// Nominal master clocks per power mode, in kHz
`define SDDF_HR_MCLK_KHZ 8192
`define SDDF_LP_MCLK_KHZ 4096
`define SDDF_VLP_MCLK_KHZ 2048

// Settling times in master clock cycles per ratio code
`define SDDF_SETTLE_128 16'h0358
`define SDDF_SETTLE_256 16'h0458
`define SDDF_SETTLE_512 16'h0658
`define SDDF_SETTLE_1024 16'h0A58
`define SDDF_SETTLE_2048 4696
`define SDDF_SETTLE_4096 8792
`define SDDF_SETTLE_8192 16984
`define SDDF_SETTLE_16384 33368

`endif

/* rtl/sddf_pkg.sv */
// Types shared by the decimation filter files
package sddf_pkg;

  // Output path; Gray codes along the startup sequence
  typedef enum logic [1:0] {
    SDDF_FAST_FIRST = 2'h0,
    SDDF_FAST_SECOND = 2'h1,
    SDDF_SINC3 = 2'h3
  } sddf_path_e;

  typedef enum logic [1:0] {
    SDDF_HIGH_RESOLUTION_MODE = 2'h2,
    SDDF_LOW_POWER_MODE = 2'h1,
    SDDF_VERY_LOW_POWER_MODE = 2'h0
  } sddf_power_e;

  typedef struct packed {
    logic enable;
    logic [2:0] decimation_ratio_field;
    logic [1:0] power_level_field;
  } sddf_clock_s;

  typedef struct packed {
    logic [1:0] mux;
    logic [2:0] gain;
  } sddf_chan_s;

  typedef struct packed {
    logic settled;
    logic [23:0] data;
  } sddf_result_s;

endpackage : sddf_pkg

/* rtl/sddf_sinc3.sv */
// Third-order sinc decimator for a one-bit stream
`timescale 1ns/1ps

module sddf_sinc3 (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic in_en,
  input wire logic in_bit,
  input wire logic [3:0] ratio_log,
  output logic out_valid,
  output logic [31:0] out_data
);

  logic [31:0] int1_ff;
  logic [31:0] int2_ff;
  logic [31:0] int3_ff;
  logic [31:0] dly1_ff;
  logic [31:0] dly2_ff;
  logic [31:0] dly3_ff;
  logic [9:0] phase_ff;
  logic [9:0] phase_last;
  logic [31:0] comb1;
  logic [31:0] comb2;
  logic [31:0] comb3;
  logic dec_hit;

  // Wrapping arithmetic is safe: the output never exceeds 2^30
  assign phase_last = 10'((11'h001 << ratio_log) - 11'h001);
  assign dec_hit = in_en && (phase_ff == phase_last);
  assign comb1 = int3_ff - dly1_ff;
  assign comb2 = comb1 - dly2_ff;
  assign comb3 = comb2 - dly3_ff;

  // Integrators at modulator rate
  always_ff @(posedge mclk) begin
    if (!rstn || clr) begin
      int1_ff <= 32'h0;
      int2_ff <= 32'h0;
      int3_ff <= 32'h0;
    end else if (in_en) begin
      int1_ff <= int1_ff + {31'h0, in_bit};
      int2_ff <= int2_ff + int1_ff;
      int3_ff <= int3_ff + int2_ff;
    end
  end

  // Decimation phase at modulator rate, combs at output rate
  always_ff @(posedge mclk) begin
    if (!rstn || clr) begin
      phase_ff <= 10'h0;
      dly1_ff <= 32'h0;
      dly2_ff <= 32'h0;
      dly3_ff <= 32'h0;
      out_valid <= 1'b0;
      out_data <= 32'h0;
    end else begin
      out_valid <= dec_hit;
      if (in_en) begin
        phase_ff <= dec_hit ? 10'h0 : phase_ff + 10'h1;
      end
      if (dec_hit) begin
        dly1_ff <= int3_ff;
        dly2_ff <= comb1;
        dly3_ff <= comb2;
        out_data <= comb3;
      end
    end
  end

endmodule : sddf_sinc3

/* rtl/sddf_filter.sv */
// Decimation filter channel with fast-settling startup path
`timescale 1ns/1ps
`include "sddf_cfg.svh"

// Summary of operation
// R1: Average the one-bit stream, decimating modulator rate to output rate.
// R2: Sinc-type linear-phase FIR low-pass suppresses out-of-band noise.
// R3: Three-bit ratio field selects 128 to 16384 in powers of two.
// R4: At 8.192 MHz high-resolution, modulator 4.096 MHz, 32k to 250 SPS.
// R5: Same ratio set at any master clock; rate scales with clock.
// R6: Bit-stream feeds a sinc3 path and a fast path in parallel.
// R7: After reset results come from the first-order fast path.
// R8: After two fast conversions switch to sinc3 until next reset.
// R9: Ratios 128 to 1024 take the sinc3 output directly.
// R10: Ratios 2048 up use sinc3 at 1024 then sinc1 by 2 to 16.
// R11: Nulls at multiples of output rate, repeating at modulator rate.
// R12: Enable, mux or gain change, or resync restart the settling.
// R13: Unsettled results are still delivered, never suppressed.
// R14: Host tracks settling and discards early results.
// R15: First ready fall after settling time carries a settled result.
// R16: Settling counts 856 to 33368 master clocks per ratio.
// R17: Modulator sample rate is master clock divided by two.
// R18: Two-bit power field selects one of three power modes.
// R19: Ratio codes 0 to 7 map to 128 through 16384 ascending.
// R20: Fast conversion count clears on reset, saturates after two.

module sddf_filter #(
  parameter int unsigned SETTLE_2048 = `SDDF_SETTLE_2048,
  parameter int unsigned SETTLE_4096 = `SDDF_SETTLE_4096,
  parameter int unsigned SETTLE_8192 = `SDDF_SETTLE_8192,
  parameter int unsigned SETTLE_16384 = `SDDF_SETTLE_16384
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mod_bit,
  input wire logic resync,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic conversion_ready_n,
  output logic [23:0] result_data,
  output logic result_settled,
  output logic [1:0] power_level
);

  //--------------------------------------------------------------
  // Helper functions
  //--------------------------------------------------------------

  // Ratio code to log2 of overall ratio
  function automatic logic [3:0] sddf_ratio_log(input logic [2:0] code);
    return `SDDF_LOG_BASE + {1'b0, code}; // [R19] [R3]
  endfunction : sddf_ratio_log

  // Unsigned count with full scale 2^fs to signed 24-bit, saturated
  function automatic logic [23:0] sddf_scale(input logic [35:0] v,
                                             input logic [5:0] fs);
    logic [35:0] sc;
    logic signed [36:0] bp;
    logic signed [36:0] sh;
    sc = v << (6'h23 - fs);
    bp = $signed({1'b0, sc}) - 37'sh4_0000_0000;
    sh = bp >>> 11;
    if (sh > 37'sh0_007F_FFFF) begin
      return 24'h7FFFFF;
    end
    return sh[23:0];
  endfunction : sddf_scale

  //--------------------------------------------------------------
  // Configuration registers
  //--------------------------------------------------------------

  sddf_pkg::sddf_clock_s clock_ff;
  sddf_pkg::sddf_chan_s chan_ff;
  sddf_pkg::sddf_clock_s nxt_clock;
  sddf_pkg::sddf_chan_s nxt_chan;
  logic wr_clock;
  logic wr_chan;
  logic rd_data;

  assign wr_clock = reg_wr && (reg_addr == `SDDF_ADDR_CLOCK);
  assign wr_chan = reg_wr && (reg_addr == `SDDF_ADDR_CHAN);
  assign rd_data = reg_rd && (reg_addr == `SDDF_ADDR_DATA);

  assign nxt_clock.enable = reg_wdata[`SDDF_EN_BIT];
  assign nxt_clock.decimation_ratio_field =
    reg_wdata[`SDDF_OSR_MSB:`SDDF_OSR_LSB];
  assign nxt_clock.power_level_field =
    reg_wdata[`SDDF_PWR_MSB:`SDDF_PWR_LSB];
  assign nxt_chan.mux = reg_wdata[`SDDF_MUX_MSB:`SDDF_MUX_LSB];
  assign nxt_chan.gain = reg_wdata[`SDDF_GAIN_MSB:`SDDF_GAIN_LSB];

  // Clock register: enable, ratio and power level
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      clock_ff.enable <= `SDDF_RST_EN;
      clock_ff.decimation_ratio_field <= `SDDF_RST_OSR;
      clock_ff.power_level_field <= `SDDF_RST_PWR;
    end else if (wr_clock) begin
      clock_ff <= nxt_clock; // [R3] [R18]
    end
  end

  // Channel register: input selection and gain
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      chan_ff.mux <= `SDDF_RST_MUX;
      chan_ff.gain <= `SDDF_RST_GAIN;
    end else if (wr_chan) begin
      chan_ff <= nxt_chan;
    end
  end

  // Power mode only scales analog bias; code 3 is held as written
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      power_level <= `SDDF_RST_PWR;
    end else begin
      power_level <= clock_ff.power_level_field; // [R18]
    end
  end

  //--------------------------------------------------------------
  // Modulator rate and restart
  //--------------------------------------------------------------

  logic mod_div_ff;
  logic mod_en;
  logic restart;
  logic [3:0] ratio_log;
  logic [3:0] s3_log;
  logic long_ratio;

  // Divider gives one enable per modulator sample
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mod_div_ff <= 1'b0;
    end else begin
      mod_div_ff <= 1'(mod_div_ff + 1'b1); // [R17]
    end
  end
  assign mod_en = mod_div_ff == 1'(`SDDF_MOD_DIV - 1); // [R17] [R5] [R4]

  // Disabled channel is held cleared, so enabling restarts it
  assign restart = resync || !clock_ff.enable || // [R12]
    (wr_clock && (nxt_clock.decimation_ratio_field !=
                  clock_ff.decimation_ratio_field)) ||
    (wr_chan && (nxt_chan != chan_ff)); // [R12]

  assign ratio_log = sddf_ratio_log(clock_ff.decimation_ratio_field);
  assign long_ratio = ratio_log > `SDDF_S3_LOG_MAX; // [R10]
  assign s3_log = long_ratio ? `SDDF_S3_LOG_MAX : ratio_log; // [R9] [R10]

  //--------------------------------------------------------------
  // Fast-settling sinc1 path
  //--------------------------------------------------------------

  logic [13:0] fast_cnt_ff;
  logic [14:0] fast_ones_ff;
  logic [14:0] fast_sum_ff;
  logic fast_done_ff;
  logic [13:0] fast_last;
  logic fast_hit;

  assign fast_last = 14'((15'h0001 << ratio_log) - 15'h0001); // [R1]
  assign fast_hit = mod_en && (fast_cnt_ff == fast_last);

  // Boxcar count of ones over one output period
  always_ff @(posedge mclk) begin
    if (!rstn || restart) begin
      fast_cnt_ff <= 14'h0;
      fast_ones_ff <= 15'h0;
      fast_sum_ff <= 15'h0;
      fast_done_ff <= 1'b0;
    end else begin
      fast_done_ff <= fast_hit;
      if (mod_en) begin
        fast_cnt_ff <= fast_hit ? 14'h0 : fast_cnt_ff + 14'h1;
        fast_ones_ff <= fast_hit ? 15'h0 : fast_ones_ff + {14'h0, mod_bit};
      end
      if (fast_hit) begin
        fast_sum_ff <= fast_ones_ff + {14'h0, mod_bit}; // [R6] [R7]
      end
    end
  end

  //--------------------------------------------------------------
  // Sinc3 path and sinc1 post-stage
  //--------------------------------------------------------------

  logic s3_valid;
  logic [31:0] s3_data;

  // Runs beside the fast path from the same stream
  sddf_sinc3 u_sinc3 ( // [R6] [R2] [R11]
    .mclk(mclk),
    .rstn(rstn),
    .clr(restart),
    .in_en(mod_en),
    .in_bit(mod_bit),
    .ratio_log(s3_log),
    .out_valid(s3_valid),
    .out_data(s3_data)
  );

  logic [3:0] s1_cnt_ff;
  logic [35:0] s1_acc_ff;
  logic [35:0] s1_sum_ff;
  logic s1_done_ff;
  logic [3:0] s1_last;
  logic s1_hit;

  assign s1_last = 4'((5'h01 << (ratio_log - `SDDF_S3_LOG_MAX)) - 5'h01);
  assign s1_hit = s3_valid && (s1_cnt_ff == s1_last);

  // Sums 2 to 16 sinc3 words for the long ratios
  always_ff @(posedge mclk) begin
    if (!rstn || restart || !long_ratio) begin
      s1_cnt_ff <= 4'h0;
      s1_acc_ff <= 36'h0;
      s1_sum_ff <= 36'h0;
      s1_done_ff <= 1'b0;
    end else begin
      s1_done_ff <= s1_hit;
      if (s3_valid) begin
        s1_cnt_ff <= s1_hit ? 4'h0 : s1_cnt_ff + 4'h1;
        s1_acc_ff <= s1_hit ? 36'h0 : s1_acc_ff + {4'h0, s3_data};
      end
      if (s1_hit) begin
        s1_sum_ff <= s1_acc_ff + {4'h0, s3_data}; // [R10]
      end
    end
  end

  //--------------------------------------------------------------
  // Path selection
  //--------------------------------------------------------------

  sddf_pkg::sddf_path_e path_ff;

  // Only a device reset returns to the fast path
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      path_ff <= sddf_pkg::SDDF_FAST_FIRST; // [R7] [R20]
    end else if (fast_done_ff) begin
      unique case (path_ff)
        sddf_pkg::SDDF_FAST_FIRST: begin
          path_ff <= sddf_pkg::SDDF_FAST_SECOND;
        end
        sddf_pkg::SDDF_FAST_SECOND: begin
          path_ff <= sddf_pkg::SDDF_SINC3; // [R8]
        end
        sddf_pkg::SDDF_SINC3: begin
          path_ff <= sddf_pkg::SDDF_SINC3; // [R20]
        end
        default: begin
          path_ff <= sddf_pkg::SDDF_SINC3;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // Result selection and scaling
  //--------------------------------------------------------------

  logic new_valid;
  logic [23:0] new_data;
  logic [5:0] fs3;

  assign fs3 = 6'({2'h0, s3_log} + {2'h0, s3_log} + {2'h0, s3_log});

  // Each path's full scale is a power of two, so scaling is a shift
  always_comb begin
    new_valid = 1'b0;
    new_data = 24'h0;
    if (path_ff != sddf_pkg::SDDF_SINC3) begin
      new_valid = fast_done_ff; // [R7]
      new_data = sddf_scale({21'h0, fast_sum_ff}, {2'h0, ratio_log});
    end else if (!long_ratio) begin
      new_valid = s3_valid; // [R9]
      new_data = sddf_scale({4'h0, s3_data}, fs3);
    end else begin
      new_valid = s1_done_ff; // [R10]
      new_data = sddf_scale(s1_sum_ff, `SDDF_S3_FS_MAX +
                            {2'h0, ratio_log - `SDDF_S3_LOG_MAX});
    end
  end

  //--------------------------------------------------------------
  // Settling timer
  //--------------------------------------------------------------

  logic [15:0] settle_cnt_ff;
  logic [15:0] settle_lim;

  // Table of settling counts per ratio code
  always_comb begin
    unique case (clock_ff.decimation_ratio_field)
      3'h0: settle_lim = `SDDF_SETTLE_128; // [R16]
      3'h1: settle_lim = `SDDF_SETTLE_256;
      3'h2: settle_lim = `SDDF_SETTLE_512;
      3'h3: settle_lim = `SDDF_SETTLE_1024;
      3'h4: settle_lim = 16'(SETTLE_2048);
      3'h5: settle_lim = 16'(SETTLE_4096);
      3'h6: settle_lim = 16'(SETTLE_8192);
      3'h7: settle_lim = 16'(SETTLE_16384);
    endcase
  end

  // Saturates so a long run never wraps back to unsettled
  always_ff @(posedge mclk) begin
    if (!rstn || restart) begin
      settle_cnt_ff <= 16'h0; // [R12]
    end else if (settle_cnt_ff != 16'hFFFF) begin
      settle_cnt_ff <= settle_cnt_ff + 16'h1; // [R16]
    end
  end

  //--------------------------------------------------------------
  // Output result and ready strobe
  //--------------------------------------------------------------

  sddf_pkg::sddf_result_s result_ff;

  // Every conversion is delivered, settled or not
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      result_ff <= '0;
    end else if (new_valid) begin
      result_ff.data <= new_data; // [R13] [R1]
      result_ff.settled <= settle_cnt_ff >= settle_lim; // [R15]
    end
  end
  assign result_data = result_ff.data;
  assign result_settled = result_ff.settled;

  // Falls on a new result; a data read in the same cycle loses
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      conversion_ready_n <= 1'b1;
    end else if (new_valid) begin
      conversion_ready_n <= 1'b0; // [R13] [R15]
    end else if (rd_data) begin
      conversion_ready_n <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // Register read port
  //--------------------------------------------------------------

  // Read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0;
    end else begin
      unique case (reg_addr)
        `SDDF_ADDR_CLOCK: begin
          reg_rdata <= {23'h0, clock_ff.enable, 3'h0,
                        clock_ff.decimation_ratio_field,
                        clock_ff.power_level_field};
        end
        `SDDF_ADDR_CHAN: begin
          reg_rdata <= {25'h0, chan_ff.gain, 2'h0, chan_ff.mux};
        end
        `SDDF_ADDR_STATUS: begin
          reg_rdata <= {27'h0, ~conversion_ready_n,
                        settle_cnt_ff >= settle_lim, path_ff,
                        path_ff == sddf_pkg::SDDF_SINC3};
        end
        `SDDF_ADDR_DATA: begin
          reg_rdata <= {8'h0, result_ff.data};
        end
        default: begin
          reg_rdata <= 32'h0;
        end
      endcase
    end
  end

endmodule : sddf_filter

/* sim/sddf_filter_properties.sv */
// Port-level checker for the decimation filter, bound to its top
`timescale 1ns/1ps
`include "sddf_cfg.svh"

module sddf_filter_properties #(
  parameter int unsigned SETTLE_2048 = `SDDF_SETTLE_2048,
  parameter int unsigned SETTLE_16384 = `SDDF_SETTLE_16384
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic resync,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic conversion_ready_n,
  input wire logic [23:0] result_data,
  input wire logic result_settled,
  input wire logic [1:0] power_level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Margins absorb the one or two cycles of restart latency
  localparam int FLOOR = (SETTLE_2048 < 856 ? SETTLE_2048 : 856) - 4;
  localparam int CEIL = (SETTLE_16384 > 2648 ? SETTLE_16384 : 2648) + 4;

  // Any config write restarts this count, so it never runs ahead
  logic [15:0] since_ff;
  always_ff @(posedge mclk) begin
    if (!rstn || resync || (reg_wr && reg_addr <= `SDDF_ADDR_CHAN)) begin
      since_ff <= 16'h0000;
    end else if (since_ff != 16'hFFFF) begin
      since_ff <= since_ff + 16'h0001;
    end
  end

  sequence s_data_read;
    reg_rd && reg_addr == `SDDF_ADDR_DATA;
  endsequence
  sequence s_new_result;
    $fell(conversion_ready_n);
  endsequence

  chk_reset_idle: assert property (
    $rose(rstn) |-> conversion_ready_n && result_data == 24'h000000
    && !result_settled) else $error("outputs not idle after reset");
  chk_power_copy: assert property (
    reg_wr && reg_addr == `SDDF_ADDR_CLOCK |=> ##1
    power_level == $past(reg_wdata[1:0], 2))
    else $error("power level differs from last write");
  chk_data_hold: assert property (
    result_data != $past(result_data) |-> !conversion_ready_n)
    else $error("result changed without ready low");
  chk_ready_rise: assert property (
    $rose(conversion_ready_n) |->
    $past(reg_rd && reg_addr == `SDDF_ADDR_DATA))
    else $error("ready rose without a data read");
  chk_read_value: assert property (
    s_data_read |=> reg_rdata == {8'h00, $past(result_data)})
    else $error("data read returned wrong word");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr > `SDDF_ADDR_DATA |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_settle_floor: assert property (
    s_new_result ##0 since_ff < FLOOR |-> !result_settled)
    else $error("result flagged settled too early");
  chk_settled_late: assert property (
    s_new_result ##0 since_ff >= CEIL |-> result_settled)
    else $error("result not flagged settled after settle time");
endmodule : sddf_filter_properties

bind sddf_filter sddf_filter_properties #(
  .SETTLE_2048(SETTLE_2048),
  .SETTLE_16384(SETTLE_16384)
) u_props (
  .mclk(mclk),
  .rstn(rstn),
  .resync(resync),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .conversion_ready_n(conversion_ready_n),
  .result_data(result_data),
  .result_settled(result_settled),
  .power_level(power_level)
);

/* sim/sddf_mod_model.sv */
// Behavioural one-bit modulator stream feeding the filter
`timescale 1ns/1ps

module sddf_mod_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] density,
  output logic mod_bit
);
  // Half-rate phase: a bit holds two master clocks
  logic phase_ff;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end

  // Alternating level flips once per modulator sample
  logic half_ff;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      half_ff <= 1'b0;
    end else if (phase_ff) begin
      half_ff <= ~half_ff;
    end
  end

  // Density 0 all zeros, 1 all ones, 2 or 3 alternating
  assign mod_bit = density[1] ? half_ff : density[0];
endmodule : sddf_mod_model

/* sim/test_sigma_delta_decimation_filter.sv */
// Self-checking bench for the decimation filter
`timescale 1ns/1ps
`include "sddf_cfg.svh"

module test_sigma_delta_decimation_filter;
  typedef struct {
    logic [2:0] code;
    logic [1:0] dens;
    logic [23:0] exp;
  } sddf_row_s;
  logic mclk, rstn, mod_bit, resync, reg_wr, reg_rd, st;
  logic conversion_ready_n, result_settled;
  logic [1:0] density, power_level;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [23:0] result_data, got;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t_w, t_u, t_prev, n;
  int t_r = 0;
  // Shortened cascade counts keep the run brief
  int settle_tbl [8] = '{`SDDF_SETTLE_128, `SDDF_SETTLE_256,
    `SDDF_SETTLE_512, `SDDF_SETTLE_1024, 600, 700, 800, 900};
  // All-ones rows only where the settle count spans more than two periods
  sddf_row_s rows [4] = '{'{3'h1, 2'h1, 24'h7FFFFF},
    '{3'h0, 2'h1, 24'h7FFFFF}, '{3'h2, 2'h0, 24'h800000},
    '{3'h3, 2'h0, 24'h800000}};

  sddf_filter #(.SETTLE_2048(600), .SETTLE_4096(700), .SETTLE_8192(800),
    .SETTLE_16384(900)) dut (.mclk(mclk), .rstn(rstn), .mod_bit(mod_bit),
    .resync(resync), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conversion_ready_n(conversion_ready_n), .result_data(result_data),
    .result_settled(result_settled), .power_level(power_level));
  sddf_mod_model u_mod (.mclk(mclk), .rstn(rstn), .density(density),
    .mod_bit(mod_bit));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard well above the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    t_w = cyc;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  // Waits for ready low, stamps the cycle, then reads the word
  task automatic next_result;
    int k = 0;
    while (conversion_ready_n !== 1'b0 && k < 40000) begin
      @(posedge mclk);
      #1 k++;
    end
    t_prev = t_r;
    t_r = cyc;
    st = result_settled;
    rd(`SDDF_ADDR_DATA);
    got = rd_val[23:0];
  endtask : next_result

  // Early results are dropped until one is flagged settled
  task automatic run_settle(input logic [2:0] code);
    logic ok;
    n = 0;
    st = 1'b0;
    while (st !== 1'b1 && n < 12) begin
      t_u = t_r;
      next_result();
      n++;
    end
    ok = t_r - t_w + 2 >= settle_tbl[code];
    ok = ok && (t_u - t_w < settle_tbl[code] + 2);
    chk("unsettled delivered", 1, n > 1);
    chk("settle window", 1, ok);
  endtask : run_settle

  initial begin
    {rstn, resync, reg_wr, reg_rd} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    density = 2'h1;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1 chk("ready_n", 1, conversion_ready_n);
    chk("power_level", 2, power_level);
    rd(`SDDF_ADDR_CLOCK);
    chk("clock word", 32'h10E, rd_val);
    rd(`SDDF_ADDR_CHAN);
    chk("chan word", 0, rd_val);
    rd(4'hA);
    chk("unmapped", 0, rd_val);
    // Startup: two fast results, then sinc3 for good
    next_result();
    chk("fast data", 24'h7FFFFF, got);
    rd(`SDDF_ADDR_STATUS);
    chk("path after one", 3'h2, rd_val[2:0]);
    next_result();
    rd(`SDDF_ADDR_STATUS);
    chk("path after two", 3'h7, rd_val[2:0]);
    next_result();
    next_result();
    chk("period 1024", 2048, t_r - t_prev);
    // Power field with a ratio change so it also restarts
    wr(`SDDF_ADDR_CLOCK, 32'h101);
    @(posedge mclk);
    #1 chk("power_level lp", 1, power_level);
    // Table of ratios and stream levels
    foreach (rows[i]) begin
      density <= rows[i].dens;
      wr(`SDDF_ADDR_CLOCK, {23'h0, 1'b1, 3'h0, rows[i].code, 2'h2});
      run_settle(rows[i].code);
      chk("settled data", rows[i].exp, got);
      next_result();
      chk("period", 1 << (8 + rows[i].code), t_r - t_prev);
    end
    // Cascaded ratio 2048: sinc3 at 1024 then sinc1 by two
    wr(`SDDF_ADDR_CLOCK, 32'h112);
    repeat (3) next_result();
    chk("cascade data", 24'h800000, got);
    chk("cascade period", 4096, t_r - t_prev);
    // Gain change and resync restart settling, path stays sinc3
    density <= 2'h1;
    wr(`SDDF_ADDR_CLOCK, 32'h102);
    run_settle(3'h0);
    wr(`SDDF_ADDR_CHAN, 32'h10);
    next_result();
    chk("gain restart", 0, st);
    rd(`SDDF_ADDR_STATUS);
    chk("path kept", 1, rd_val[0]);
    run_settle(3'h0);
    @(posedge mclk);
    resync <= 1'b1;
    @(posedge mclk);
    resync <= 1'b0;
    next_result();
    chk("resync restart", 0, st);
    // Second reset in mid-run returns to the fast path
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rd(`SDDF_ADDR_STATUS);
    chk("path reset", 0, rd_val[2:0]);
    rd(`SDDF_ADDR_CLOCK);
    chk("clock reset", 32'h10E, rd_val);
    give_verdict();
  end
endmodule : test_sigma_delta_decimation_filter
